/* core/cfg_status_map.vh */
// Purpose: constants for the bus status / identification bank
// Assumes: included by bare name
// Notes: definitions only
`ifndef CFG_STATUS_MAP_VH
`define CFG_STATUS_MAP_VH
// register select codes on the config port (word granularity, chosen)
`define SEL_ID_VENDOR      3'h0
`define SEL_CMD_STATUS     3'h1
`define SEL_REVISION       3'h2
`define SEL_BOARD_IDENT    3'h3
`define SEL_DIAG           3'h4
`define SEL_EE_STATION     3'h5
// status bit positions
`define ST_CAP_BIT         4
`define ST_FAST_BIT        7
`define ST_MPERR_BIT       8
`define ST_DEVSEL_LO       9
`define ST_DEVSEL_HI       10
`define ST_TABORT_TX_BIT   11
`define ST_TABORT_RX_BIT   12
`define ST_MABORT_BIT      13
`define ST_SERR_BIT        14
`define ST_PERR_BIT        15
`define DEVSEL_MEDIUM      2'h1
// command bit positions
`define CMD_PARITY_BIT     6
`define CMD_SERR_BIT       8
`define CMD_WMASK          16'h0157
`define CMD_RESET          16'h0000
// eeprom word addresses
`define EE_BUS_PARAM       8'h08
`define EE_STATION0        8'h0a
`define EE_BOARD_MAKER     8'h17
`define EE_BOARD_ID        8'h18
`define EE_FAST_BIT        0
`endif

/* core/status_flags.v */
// Purpose: write-one-to-clear sticky event flags
// Assumes: events are single-cycle or level, synchronous to clk
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
module status_flags #(
  parameter N = 6
) (
  input wire clk, // clock
  input wire reset, // async reset, active high
  input wire ce, // clock enable
  input wire [N-1:0] set_evt, // event strobes
  input wire [N-1:0] clr_w1, // write-one clear strobes
  output wire [N-1:0] flags // sticky flags
);
  reg [N-1:0] flag_r;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_flag
      always @(posedge clk or posedge reset)
      begin
        if (reset)
          flag_r[i] <= 1'b0;
        else if (ce)
        begin
          if (set_evt[i])
            flag_r[i] <= 1'b1;
          else if (clr_w1[i])
            flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate
  assign flags = flag_r;
endmodule

/* core/ident_loader.v */
// Purpose: fetch identity words from serial eeprom after reset
// Assumes: word-read port answers with ee_ack after ee_req
// Notes: one request outstanding at a time
`timescale 1ns/1ps
`include "cfg_status_map.vh"
module ident_loader (
  input wire clk, // clock
  input wire reset, // async reset, active high
  input wire ce, // clock enable
  output reg ee_req, // word read request, held until ack
  output reg [7:0] ee_addr, // word address
  input wire ee_ack, // read data valid pulse
  input wire [15:0] ee_data, // read data
  output reg [15:0] bus_param_r, // bus parameter word
  output reg [15:0] board_maker_r, // board maker ident
  output reg [15:0] board_id_r, // board ident
  output reg [47:0] station_r, // alternate station address
  output reg done // load finished
);
  reg [2:0] step_r;
  always @*
  begin
    case (step_r)
      3'd0: ee_addr = `EE_BUS_PARAM;
      3'd1: ee_addr = `EE_BOARD_MAKER;
      3'd2: ee_addr = `EE_BOARD_ID;
      3'd3: ee_addr = `EE_STATION0;
      3'd4: ee_addr = `EE_STATION0 + 8'h01;
      3'd5: ee_addr = `EE_STATION0 + 8'h02;
      default: ee_addr = 8'h00;
    endcase
    ee_req = (step_r < 3'd6);
  end
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      step_r <= 3'd0;
      bus_param_r <= 16'h0000;
      board_maker_r <= 16'h0000;
      board_id_r <= 16'h0000;
      station_r <= 48'h0000_0000_0000;
      done <= 1'b0;
    end
    else if (ce && ee_req && ee_ack)
    begin
      case (step_r)
        3'd0: bus_param_r <= ee_data;
        3'd1: board_maker_r <= ee_data;
        3'd2: board_id_r <= ee_data;
        3'd3: station_r[15:0] <= ee_data;
        3'd4: station_r[31:16] <= ee_data;
        3'd5: station_r[47:32] <= ee_data;
        default: station_r <= station_r;
      endcase
      step_r <= step_r + 3'd1;
      if (step_r == 3'd5)
        done <= 1'b1;
    end
  end
endmodule

/* core/cfg_status_bank.v */
// Purpose: bus status, command and identification registers
// Assumes: config port is synchronous; one access per cycle
// Notes: board ids are loaded from eeprom after reset; maker code and revision are parameters
`timescale 1ns/1ps
`include "cfg_status_map.vh"
module cfg_status_bank #(
  parameter [15:0] MAKER_CODE = 16'h1234, // arbitrary value
  parameter [2:0] SILICON_REV = 3'h1,
  parameter [2:0] CHIP_TYPE = 3'h2
) (
  input wire clk, // clock
  input wire reset, // async reset, active high
  input wire ce, // clock enable
  input wire cfg_rd, // config read strobe
  input wire cfg_wr, // config write strobe
  input wire [2:0] cfg_sel, // register select
  input wire [3:0] cfg_be, // byte enables
  input wire [31:0] cfg_wdata, // write data
  output reg [31:0] cfg_rdata, // read data, registered
  output reg cfg_ack, // read/write done pulse
  input wire perr_seen_master, // PERR# seen while master
  input wire parity_fault, // any parity error detected
  input wire tabort_sent, // target-abort signalled as target
  input wire tabort_got, // target-abort received as master
  input wire mabort_got, // master-abort as master
  input wire syserr_req, // logic wants to signal system error
  output wire syserr_o, // SERR# drive (active low level)
  output wire syserr_oe, // SERR# output enable
  output wire [4:0] diag_revision_mirror, // diagnostic revision field
  output wire [47:0] alt_station, // alternate station address
  output wire ids_loaded, // eeprom load done
  output wire ee_req, // eeprom word request
  output wire [7:0] ee_addr, // eeprom word address
  input wire ee_ack, // eeprom word valid
  input wire [15:0] ee_data // eeprom word data
);
  ////////////////////////////////////////////////////////////////
  reg [15:0] cmd_r;
  reg [15:0] cmd_nxt;
  reg [31:0] rdata_nxt;
  wire [15:0] bus_param;
  wire [15:0] board_maker;
  wire [15:0] board_id;
  wire [5:0] flags;
  wire [5:0] evt;
  wire [5:0] clr;
  wire [15:0] status;
  wire [7:0] silicon_revision;
  wire [15:0] maker_identifier;
  wire wr_status;
  wire wr_cmd_lo;
  wire wr_cmd_hi;
  wire sel_cmd;
  wire [15:0] cmd_wdata_masked;
  wire cap_chain_present;
  wire fast_consecutive_target;
  wire [1:0] decode_speed_code;
  wire master_perr_seen;
  wire target_abort_sent;
  wire target_abort_got;
  wire master_abort_got;
  wire syserr_driven;
  wire any_parity_fault;
  wire parity_react_enable;
  wire syserr_drive_enable;
  wire syserr_fire;

  assign parity_react_enable = cmd_r[`CMD_PARITY_BIT];
  assign syserr_drive_enable = cmd_r[`CMD_SERR_BIT];
  // serr only leaves when the driver is enabled
  assign syserr_fire = syserr_req & syserr_drive_enable;
  assign syserr_oe = syserr_fire;
  assign syserr_o = 1'b0;

  ////////////////////////////////////////////////////////////////
  ident_loader u_loader (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .ee_req(ee_req),
    .ee_addr(ee_addr),
    .ee_ack(ee_ack),
    .ee_data(ee_data),
    .bus_param_r(bus_param),
    .board_maker_r(board_maker),
    .board_id_r(board_id),
    .station_r(alt_station),
    .done(ids_loaded)
  );

  ////////////////////////////////////////////////////////////////
  // flag order: 8, 11, 12, 13, 14, 15
  assign evt[0] = perr_seen_master & parity_react_enable;
  assign evt[1] = tabort_sent;
  assign evt[2] = tabort_got;
  assign evt[3] = mabort_got;
  assign evt[4] = syserr_fire;
  assign evt[5] = parity_fault;
  assign sel_cmd = (cfg_sel == `SEL_CMD_STATUS);
  assign wr_status = ce & cfg_wr & sel_cmd;
  assign wr_cmd_lo = wr_status & cfg_be[0];
  assign wr_cmd_hi = wr_status & cfg_be[1];
  // unimplemented command bits are masked here so they always read zero
  assign cmd_wdata_masked = cfg_wdata[15:0] & `CMD_WMASK;
  // bit 8 lives in byte 3 lane 0 of the word; be[2] covers bits 23:16
  assign clr[0] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_MPERR_BIT];
  assign clr[1] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_TABORT_TX_BIT];
  assign clr[2] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_TABORT_RX_BIT];
  assign clr[3] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_MABORT_BIT];
  assign clr[4] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_SERR_BIT];
  assign clr[5] = wr_status & cfg_be[3] & cfg_wdata[16 + `ST_PERR_BIT];

  status_flags #(.N(6)) u_flags (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .set_evt(evt),
    .clr_w1(clr),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////
  // named status fields; bits 6:5 and 3:0 are unused and read zero
  assign cap_chain_present = 1'b1;
  // fast bit reads zero until the parameter word has been fetched
  assign fast_consecutive_target = bus_param[`EE_FAST_BIT];
  assign decode_speed_code = `DEVSEL_MEDIUM;
  assign master_perr_seen = flags[0];
  assign target_abort_sent = flags[1];
  assign target_abort_got = flags[2];
  assign master_abort_got = flags[3];
  assign syserr_driven = flags[4];
  assign any_parity_fault = flags[5];
  assign status = {any_parity_fault, syserr_driven, master_abort_got, target_abort_got, target_abort_sent,
                   decode_speed_code, master_perr_seen, fast_consecutive_target, 2'b00, cap_chain_present,
                   4'h0};

  ////////////////////////////////////////////////////////////////
  assign silicon_revision = {CHIP_TYPE, SILICON_REV, 2'b00};
  assign diag_revision_mirror = silicon_revision[6:2];
  assign maker_identifier = MAKER_CODE;

  ////////////////////////////////////////////////////////////////
  // command register; status flags above only clear on a written one, and
  // read-only fields ignore any data written to them
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      cmd_r <= `CMD_RESET;
    else if (ce)
      cmd_r <= cmd_nxt;
  end

  // each byte lane updates on its own enable
  always @*
  begin
    cmd_nxt = cmd_r;
    if (wr_cmd_lo)
      cmd_nxt[7:0] = cmd_wdata_masked[7:0];
    if (wr_cmd_hi)
      cmd_nxt[15:8] = cmd_wdata_masked[15:8];
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
    end
    else if (ce)
    begin
      cfg_ack <= cfg_rd | cfg_wr;
      cfg_rdata <= rdata_nxt;
    end
  end

  // read data holds between reads, so a slow master may sample it late
  always @*
  begin
    rdata_nxt = cfg_rdata;
    if (cfg_rd)
    begin
      case (cfg_sel)
        `SEL_ID_VENDOR: rdata_nxt = {16'h0000, maker_identifier};
        `SEL_CMD_STATUS: rdata_nxt = {status, cmd_r};
        `SEL_REVISION: rdata_nxt = {24'h00_0000, silicon_revision};
        `SEL_BOARD_IDENT: rdata_nxt = {board_id, board_maker};
        `SEL_DIAG: rdata_nxt = {27'h000_0000, diag_revision_mirror};
        `SEL_EE_STATION: rdata_nxt = alt_station[31:0];
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
endmodule

/* sim/ee_word_model.sv */
// Purpose: stand-in for the serial eeprom word-read port
// Assumes: request held until ack
// Notes: word a reads {a, 8'hc3}; data line garbles outside ack
`timescale 1ns/1ps
module ee_word_model (
  input wire clk, // clock
  input wire reset, // async reset
  input wire ee_req, // word request
  input wire [7:0] ee_addr, // word address
  input wire [1:0] wait_cycles, // answer delay
  output logic ee_ack, // data valid pulse
  output logic [15:0] ee_data // word data
);
  logic [1:0] cnt_r;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= 2'h0;
      ee_ack <= 1'b0;
      ee_data <= 16'h0000;
    end
    else if (ee_req && !ee_ack && cnt_r == wait_cycles)
    begin
      cnt_r <= 2'h0;
      ee_ack <= 1'b1;
      ee_data <= {ee_addr, 8'hc3};
    end
    else
    begin
      // stale data must not look valid
      cnt_r <= (ee_req && !ee_ack) ? cnt_r + 2'h1 : 2'h0;
      ee_ack <= 1'b0;
      ee_data <= ~ee_data;
    end
  end
endmodule

/* sim/cfg_status_bank_properties.sv */
// Purpose: port checker for the status bank
// Assumes: single clock domain
// Notes: bound to every instance
`timescale 1ns/1ps
module cfg_status_props #(
  parameter [15:0] MAKER_CODE = 16'h1234,
  parameter [2:0] SILICON_REV = 3'h1,
  parameter [2:0] CHIP_TYPE = 3'h2
) (
  input wire clk, // clock
  input wire reset, // async reset
  input wire ce, // clock enable
  input wire cfg_rd, // read strobe
  input wire [2:0] cfg_sel, // select
  input wire [31:0] cfg_rdata, // read data
  input wire cfg_ack, // done pulse
  input wire syserr_req, // error request
  input wire syserr_o, // SERR# level
  input wire syserr_oe, // SERR# enable
  input wire [4:0] diag_revision_mirror, // mirror
  input wire ids_loaded, // load done
  input wire ee_req, // word request
  input wire [7:0] ee_addr, // word address
  input wire ee_ack // word valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_cap_bit_set: assert property (cfg_ack && $past(cfg_rd && ce && cfg_sel == 3'h1) |-> cfg_rdata[20])
    else $error("capability bit low");
  a_decode_speed: assert property (cfg_ack && $past(cfg_rd && ce && cfg_sel == 3'h1)
    |-> cfg_rdata[26:25] == 2'b01) else $error("decode speed wrong");
  a_rev_layout: assert property (cfg_ack && $past(cfg_rd && ce && cfg_sel == 3'h2)
    |-> cfg_rdata[7:0] == {CHIP_TYPE, SILICON_REV, 2'b00}) else $error("revision wrong");
  a_maker_const: assert property (cfg_ack && $past(cfg_rd && ce && cfg_sel == 3'h0)
    |-> cfg_rdata[15:0] == MAKER_CODE) else $error("maker code wrong");
  a_diag_mirror: assert property (diag_revision_mirror == {CHIP_TYPE[1:0], SILICON_REV})
    else $error("diag mirror wrong");
  a_serr_gated: assert property (syserr_oe |-> syserr_req && !syserr_o)
    else $error("SERR# driven without cause");
  a_maker_word_next: assert property (ee_req && ee_ack && ee_addr == 8'h08 |=> ee_addr == 8'h17)
    else $error("word 17h not fetched");
  a_board_word_next: assert property (ee_req && ee_ack && ee_addr == 8'h17 |=> ee_addr == 8'h18)
    else $error("word 18h not fetched");
  a_station_first: assert property (ee_req && ee_ack && ee_addr == 8'h18 |=> ee_addr == 8'h0a)
    else $error("station words not fetched");
  a_load_finish: assert property (ee_req && ee_ack && ee_addr == 8'h0c |=> ids_loaded && !ee_req)
    else $error("load did not finish");
endmodule
bind cfg_status_bank cfg_status_props #(.MAKER_CODE(MAKER_CODE), .SILICON_REV(SILICON_REV),
  .CHIP_TYPE(CHIP_TYPE)) u_props (.clk, .reset, .ce, .cfg_rd, .cfg_sel, .cfg_rdata, .cfg_ack,
  .syserr_req, .syserr_o, .syserr_oe, .diag_revision_mirror, .ids_loaded, .ee_req, .ee_addr, .ee_ack);

/* sim/tb_cfg_status_bank.sv */
// Purpose: self-checking bench for the status bank
// Assumes: ce held high except while t_freeze checks that it freezes state
// Notes: inputs change on falling edges
`timescale 1ns/1ps
module tb_cfg_status_bank;
  localparam [15:0] BASE = 16'h0290; // cap, fast (word 08 bit 0 set), medium decode
  logic clk, reset, cfg_rd, cfg_wr, syserr_req, syserr_o, syserr_oe, cfg_ack, ids_loaded, ee_req, ee_ack, ce;
  logic [2:0] cfg_sel;
  logic [3:0] cfg_be;
  logic [4:0] ev, diag_revision_mirror;
  logic [1:0] wait_cycles;
  logic [7:0] ee_addr;
  logic [15:0] ee_data;
  logic [31:0] cfg_wdata, cfg_rdata, rv;
  logic [47:0] alt_station;
  int num_errors = 0;
  int num_checks = 0;
  cfg_status_bank #(.MAKER_CODE(16'h5a3c), .SILICON_REV(3'h5), .CHIP_TYPE(3'h6)) dut (.clk, .reset,
    .ce, .cfg_rd, .cfg_wr, .cfg_sel, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
    .perr_seen_master(ev[0]), .parity_fault(ev[1]), .tabort_sent(ev[2]), .tabort_got(ev[3]),
    .mabort_got(ev[4]), .syserr_req, .syserr_o, .syserr_oe, .diag_revision_mirror, .alt_station,
    .ids_loaded, .ee_req, .ee_addr, .ee_ack, .ee_data);
  ee_word_model ee (.clk, .reset, .ee_req, .ee_addr, .wait_cycles, .ee_ack, .ee_data);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [47:0] e, input logic [47:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input logic w, input logic [2:0] s, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    {cfg_rd, cfg_wr, cfg_sel, cfg_be, cfg_wdata} = {!w, w, s, b, d};
    @(negedge clk);
    {cfg_rd, cfg_wr} = 2'b00;
    rv = cfg_rdata;
    chk("ack", 1'b1, cfg_ack);
  endtask
  task pulse(input logic [4:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 0;
  endtask
  task clr;
    acc(1, 3'h1, 4'hc, 32'hffff_0000);
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("cleared", BASE, rv[31:16]);
  endtask
  task do_reset;
    reset = 1;
    repeat (20) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 200 && ids_loaded !== 1'b1; i++) @(negedge clk);
  endtask
  task t_ids;
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("status", BASE, rv[31:16]);
    chk("command", 16'h0000, rv[15:0]);
    acc(1, 3'h0, 4'hf, 32'hffff_ffff);
    acc(0, 3'h0, 4'hf, 32'h0000_0000);
    chk("maker", 16'h5a3c, rv[15:0]);
    acc(0, 3'h2, 4'hf, 32'h0000_0000);
    chk("revision", 8'hd4, rv[7:0]);
    acc(0, 3'h3, 4'hf, 32'h0000_0000);
    chk("board", 32'h18c3_17c3, rv);
    chk("station", 48'h0cc3_0bc3_0ac3, alt_station);
    chk("diag", 5'h15, diag_revision_mirror);
    $display("t_ids done");
  endtask
  task t_flags;
    int b[5] = '{8, 15, 11, 12, 13};
    for (int i = 1; i < 5; i++)
    begin
      pulse(5'h1 << i);
      acc(0, 3'h1, 4'hf, 32'h0000_0000);
      chk("flag", 1'b1, rv[16 + b[i]]);
      clr;
    end
    pulse(5'h01);
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("perr off", 1'b0, rv[24]);
    clr;
    acc(1, 3'h1, 4'h3, 32'h0000_0040);
    pulse(5'h01);
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("perr on", 1'b1, rv[24]);
    clr;
    $display("t_flags done");
  endtask
  task t_serr(input logic en);
    acc(1, 3'h1, 4'h3, {23'h0, en, 8'h40});
    @(negedge clk);
    syserr_req = 1;
    #1 chk("serr oe", en, syserr_oe);
    @(negedge clk);
    syserr_req = 0;
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("serr flag", en, rv[30]);
    clr;
    $display("t_serr done");
  endtask
  task t_race;
    @(negedge clk);
    {cfg_wr, cfg_sel, cfg_be, cfg_wdata, ev} = {1'b1, 3'h1, 4'hc, 32'h0800_0000, 5'h04};
    @(negedge clk);
    {cfg_wr, ev} = 0;
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("race", 1'b1, rv[27]);
    clr;
    $display("t_race done");
  endtask
  task t_freeze;
    @(negedge clk);
    {ce, ev} = {1'b0, 5'h04};
    @(negedge clk);
    {ce, ev} = {1'b1, 5'h00};
    acc(0, 3'h1, 4'hf, 32'h0000_0000);
    chk("frozen flag", 1'b0, rv[27]);
    $display("t_freeze done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    finish_test;
  end
  initial
  begin
    {cfg_rd, cfg_wr, syserr_req, ev, cfg_sel, cfg_be, cfg_wdata} = 0;
    ce = 1'b1;
    wait_cycles = 2'h2;
    do_reset;
    t_ids;
    t_flags;
    t_serr(1'b0);
    t_serr(1'b1);
    t_race;
    t_freeze;
    wait_cycles = 2'h0;
    do_reset;
    t_ids;
    finish_test;
  end
endmodule
